// *** hw/rse_pkg.sv ***
// Constants, field layouts and carrier types of the reading string encoder
package rse_pkg;
  // Clock and timestamp timebase
  localparam int CLK_KHZ = 10000;
  localparam int TICK_US = 1;
  localparam int TICK_CYC = (TICK_US * CLK_KHZ + 999) / 1000;
  localparam logic [31:0] TS_LIMIT = 32'hFFFF_FFFF;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_STAT = 12'h004;
  localparam logic [11:0] OFS_TIME = 12'h008;
  localparam logic [11:0] OFS_EVT = 12'h00C;
  localparam logic [11:0] OFS_LTS = 12'h010;
  // Control fields
  localparam int CTL_SEL = 0;
  localparam int CTL_DELTA = 4;
  localparam int CTL_SORT = 5;
  localparam int CTL_TSRST = 8;
  localparam int CTL_BUFRST = 9;
  localparam logic [5:0] CTRL_RST = 6'h0F;
  // Status word fields
  localparam int ST_W = 24;
  localparam int ST_OVR1 = 0;
  localparam int ST_OVR2 = 1;
  localparam int ST_FILT = 2;
  localparam int ST_LIM1 = 3;
  localparam int ST_LIM2 = 4;
  localparam int ST_REL1 = 5;
  localparam int ST_REL2 = 6;
  localparam int ST_LEN = 7;
  localparam int ST_CODE = 8;
  localparam int ST_OUT1 = 13;
  localparam int ST_OUT2 = 14;
  localparam logic [4:0] CODE_ALL_FAIL = 5'h1F;
  // Measurement event flags
  localparam int EVT_W = 6;
  localparam int EVT_TEST_ONE_FAIL = 0;
  localparam int EVT_TEST_TWO_FAIL = 1;
  localparam int EVT_TEST_THREE_FAIL = 2;
  localparam int EVT_TEST_FOUR_FAIL = 3;
  localparam int EVT_UPPER_FAIL = 4;
  localparam int EVT_ALL_PASS = 5;
  // Not-a-number pattern for a missing current, +9.91e37 single precision
  localparam logic [31:0] NAN_VALUE = 32'h7E95_1BF3;
  typedef enum logic [1:0] {K_CH1 = 2'd0, K_CH2 = 2'd1, K_TIME = 2'd2, K_STAT = 2'd3} rse_kind_t;
  // One reading as delivered by the measurement logic
  typedef struct packed {
    logic [31:0] ch_one_current;
    logic [31:0] ch_two_current;
    logic ch_one_avail;
    logic ch_two_avail;
    logic ch_one_overrange;
    logic ch_two_overrange;
    logic filtered;
    logic ch_one_source_limited;
    logic ch_two_source_limited;
    logic ch_one_rel_on;
    logic ch_two_rel_on;
    logic limit_test_function;
    logic ch_one_output_on;
    logic ch_two_output_on;
    logic [2:0] test_num;
    logic upper_fail;
    logic all_fail;
    logic buffered;
  } rse_reading_t;
  // One element of the outgoing string
  typedef struct packed {
    rse_kind_t kind;
    logic [31:0] data;
    logic last;
  } rse_elem_t;
endpackage : rse_pkg

// *** hw/rse_encoder.sv ***
// Reading string encoder: element selection, timestamps, status word, APB registers
//
// Overview of operation
// R1 - Any subset of four elements selectable
// R2 - Host separates list entries by commas
// R3 - Selection applies to every returned string
// R4 - All four elements selected after reset
// R5 - Missing current sends +9.91e37
// R6 - Timer starts at zero, reset command
// R7 - Timer wraps to zero at limit
// R8 - Buffered stamps absolute or delta format
// R9 - Status is a 24-bit word
// R10 - Bits 0,1 flag channel overrange
// R11 - Bit 2 flags filtered measurement
// R12 - Bits 3,4 flag source compliance
// R13 - Bits 5,6 flag relative null on
// R14 - Bit 7 flags limit test enabled
// R15 - Bits 13,14 flag source output on
// R16 - Bits 8 to 12 are encoded code
// R17 - Grading: pass, test one, two codes
// R18 - Grading: low fails three to six
// R19 - Grading: high fail sets bit 12; a high fail on test one or two leaves it clear
// R20 - Grading raises matching measurement event flag; a test five high fail raises no flag
// R21 - Sorting: pass zeros, all fail ones
// R22 - Bit 15 and above read zero
// R23 - Fixed element order, unselected ones omitted
`timescale 1ns/10ps
`default_nettype none
module rse_encoder
  import rse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic rd_valid,
  input wire rse_reading_t rd,
  output logic rd_ready,
  output logic el_valid,
  output rse_elem_t el,
  input wire logic el_ready
);

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_C1 = 3'b001,
    S_C2 = 3'b011,
    S_TS = 3'b010,
    S_ST = 3'b110
  } rse_st_t;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic rse_st_t st_of(input logic [1:0] i);
    case (i)
      2'd0: st_of = S_C1;
      2'd1: st_of = S_C2;
      2'd2: st_of = S_TS;
      default: st_of = S_ST;
    endcase
  endfunction : st_of

  // First selected element at or after position from
  function automatic rse_st_t pick(input logic [2:0] from, input logic [3:0] sel);
    rse_st_t r;
    r = S_IDLE;
    for (int i = 3; i >= 0; i--) begin
      if (3'(i) >= from && sel[i]) begin
        r = st_of(2'(i));
      end
    end
    pick = r;
  endfunction : pick

  function automatic logic [2:0] pos_of(input rse_st_t s);
    case (s)
      S_C1: pos_of = 3'd0;
      S_C2: pos_of = 3'd1;
      S_TS: pos_of = 3'd2;
      default: pos_of = 3'd3;
    endcase
  endfunction : pos_of

  // Limit code in bits 12..8
  function automatic logic [4:0] limit_code(input rse_reading_t r, input logic sort);
    if (sort) begin
      limit_code = r.all_fail ? CODE_ALL_FAIL : {2'b00, r.test_num}; // R21
    end else begin
      limit_code = {r.upper_fail && r.test_num >= 3'd3, 1'b0, r.test_num}; // R17 R18 R19
    end
  endfunction : limit_code

  //////////////////////////////////////////////////////////////////////////////
  // Registers and state

  logic [5:0] ctrl_reg;
  logic ts_rst_reg;
  logic buf_rst_reg;
  logic [ST_W-1:0] status_reg;
  logic [EVT_W-1:0] evt_reg;
  logic [31:0] ts_reg;
  logic [31:0] lts_reg;
  logic [31:0] tick_reg;
  logic first_pend_reg;
  logic [31:0] base_reg;
  logic [31:0] prev_reg;
  logic [31:0] c1_reg;
  logic [31:0] c2_reg;
  rse_st_t st_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic rd_ready_reg;
  logic el_valid_reg;
  rse_elem_t el_reg;
  logic [3:0] sel_reg;

  logic setup;
  logic wr_en;
  logic mapped;
  logic accept;
  logic advance;
  logic tick;
  logic [ST_W-1:0] status_next;
  logic [EVT_W-1:0] evt_hit;
  logic [31:0] ts_next;
  logic [31:0] c1_next;
  logic [31:0] c2_next;

  assign setup = psel && !penable;
  assign wr_en = psel && penable && pready_reg && pwrite;
  assign mapped = paddr == OFS_CTRL || paddr == OFS_STAT || paddr == OFS_TIME ||
                  paddr == OFS_EVT || paddr == OFS_LTS;
  assign accept = rd_valid && rd_ready_reg;
  assign advance = el_valid_reg && el_ready;
  assign tick = tick_reg == 32'(TICK_CYC - 1);

  //////////////////////////////////////////////////////////////////////////////
  // APB slave: one wait-free access phase after each setup

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= setup;
      pslverr_reg <= setup && !mapped;
      if (setup) begin
        case (paddr)
          OFS_CTRL: prdata_reg <= {26'h000_0000, ctrl_reg};
          OFS_STAT: prdata_reg <= {8'h00, status_reg};
          OFS_TIME: prdata_reg <= ts_reg;
          OFS_EVT: prdata_reg <= {26'h000_0000, evt_reg};
          OFS_LTS: prdata_reg <= lts_reg;
          default: prdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control word; command bits only pulse and read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= CTRL_RST; // R4
      ts_rst_reg <= 1'b0;
      buf_rst_reg <= 1'b0;
    end else begin
      ts_rst_reg <= wr_en && paddr == OFS_CTRL && pwdata[CTL_TSRST];
      buf_rst_reg <= wr_en && paddr == OFS_CTRL && pwdata[CTL_BUFRST];
      if (wr_en && paddr == OFS_CTRL) begin
        ctrl_reg <= pwdata[5:0]; // R1
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Relative timestamp timer in microseconds

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_reg <= 32'h0000_0000;
      ts_reg <= 32'h0000_0000;
    end else if (ts_rst_reg) begin
      tick_reg <= 32'h0000_0000; // R6
      ts_reg <= 32'h0000_0000; // R6
    end else begin
      tick_reg <= tick ? 32'h0000_0000 : tick_reg + 32'h0000_0001;
      if (tick) begin
        ts_reg <= (ts_reg == TS_LIMIT) ? 32'h0000_0000 : ts_reg + 32'h0000_0001; // R7
      end
    end
  end

  // Buffered readings: first one stamps zero, later ones absolute or delta
  always_comb begin
    if (!rd.buffered) begin
      ts_next = ts_reg;
    end else if (first_pend_reg) begin
      ts_next = 32'h0000_0000; // R8
    end else if (ctrl_reg[CTL_DELTA]) begin
      ts_next = ts_reg - prev_reg; // R8
    end else begin
      ts_next = ts_reg - base_reg; // R8
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      first_pend_reg <= 1'b1;
      base_reg <= 32'h0000_0000;
      prev_reg <= 32'h0000_0000;
      lts_reg <= 32'h0000_0000;
    end else begin
      if (buf_rst_reg) begin
        first_pend_reg <= 1'b1;
      end else if (accept && rd.buffered) begin
        first_pend_reg <= 1'b0;
      end
      if (accept && rd.buffered && first_pend_reg) begin
        base_reg <= ts_reg;
      end
      if (accept && rd.buffered) begin
        prev_reg <= ts_reg;
      end
      if (accept) begin
        lts_reg <= ts_next;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Status word and measurement events

  always_comb begin
    status_next = '0; // R22
    status_next[ST_OVR1] = rd.ch_one_overrange; // R10
    status_next[ST_OVR2] = rd.ch_two_overrange; // R10
    status_next[ST_FILT] = rd.filtered; // R11
    status_next[ST_LIM1] = rd.ch_one_source_limited; // R12
    status_next[ST_LIM2] = rd.ch_two_source_limited; // R12
    status_next[ST_REL1] = rd.ch_one_rel_on; // R13
    status_next[ST_REL2] = rd.ch_two_rel_on; // R13
    status_next[ST_LEN] = rd.limit_test_function; // R14
    status_next[ST_CODE +: 5] = limit_code(rd, ctrl_reg[CTL_SORT]); // R16
    status_next[ST_OUT1] = rd.ch_one_output_on; // R15
    status_next[ST_OUT2] = rd.ch_two_output_on; // R15
  end

  // Sorting mode raises the test four flag for test three and the upper flag for test four; an all-fail sort raises nothing
  always_comb begin
    evt_hit = '0;
    if (rd.limit_test_function && !(ctrl_reg[CTL_SORT] && rd.all_fail)) begin
      case (rd.test_num)
        3'd0: evt_hit[EVT_ALL_PASS] = !rd.all_fail; // R20
        3'd1: evt_hit[EVT_TEST_ONE_FAIL] = 1'b1; // R20
        3'd2: evt_hit[EVT_TEST_TWO_FAIL] = 1'b1; // R20
        3'd3: evt_hit[ctrl_reg[CTL_SORT] ? EVT_TEST_FOUR_FAIL :
                      (rd.upper_fail ? EVT_UPPER_FAIL : EVT_TEST_THREE_FAIL)] = 1'b1; // R20
        3'd4: evt_hit[ctrl_reg[CTL_SORT] ? EVT_UPPER_FAIL :
                      (rd.upper_fail ? EVT_UPPER_FAIL : EVT_TEST_FOUR_FAIL)] = 1'b1; // R20
        3'd6: evt_hit[EVT_UPPER_FAIL] = rd.upper_fail && !ctrl_reg[CTL_SORT]; // R20
        default: evt_hit = '0;
      endcase
    end
  end

  // Sticky events; a new event beats a same-cycle write-one clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      evt_reg <= '0;
    end else begin
      evt_reg <= (evt_reg & ~((wr_en && paddr == OFS_EVT) ? pwdata[EVT_W-1:0] : '0)) |
                 (accept ? evt_hit : '0);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= '0;
    end else if (accept) begin
      status_reg <= status_next; // R9
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // String sequencer

  assign c1_next = rd.ch_one_avail ? rd.ch_one_current : NAN_VALUE; // R5
  assign c2_next = rd.ch_two_avail ? rd.ch_two_current : NAN_VALUE; // R5

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_reg <= 32'h0000_0000;
      c2_reg <= 32'h0000_0000;
    end else if (accept) begin
      c1_reg <= c1_next;
      c2_reg <= c2_next;
    end
  end

  // Selection is latched at take, so a control write mid-string cannot truncate or pad it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg <= S_IDLE;
      rd_ready_reg <= 1'b1;
      el_valid_reg <= 1'b0;
      el_reg <= '0;
      sel_reg <= 4'h0;
    end else if (accept) begin
      sel_reg <= ctrl_reg[3:0]; // R3
      st_reg <= pick(3'd0, ctrl_reg[3:0]); // R3
      rd_ready_reg <= pick(3'd0, ctrl_reg[3:0]) == S_IDLE;
      el_valid_reg <= pick(3'd0, ctrl_reg[3:0]) != S_IDLE;
      el_reg.kind <= rse_kind_t'(pos_of(pick(3'd0, ctrl_reg[3:0])));
      el_reg.last <= pick(pos_of(pick(3'd0, ctrl_reg[3:0])) + 3'd1, ctrl_reg[3:0]) == S_IDLE;
      case (pick(3'd0, ctrl_reg[3:0]))
        S_C1: el_reg.data <= c1_next;
        S_C2: el_reg.data <= c2_next;
        S_TS: el_reg.data <= ts_next;
        default: el_reg.data <= {8'h00, status_next};
      endcase
    end else if (advance) begin
      if (el_reg.last) begin
        st_reg <= S_IDLE;
        rd_ready_reg <= 1'b1;
        el_valid_reg <= 1'b0;
      end else begin
        st_reg <= pick(pos_of(st_reg) + 3'd1, sel_reg); // R23
        el_reg.kind <= rse_kind_t'(pos_of(pick(pos_of(st_reg) + 3'd1, sel_reg))); // R23
        el_reg.last <= pick(pos_of(pick(pos_of(st_reg) + 3'd1, sel_reg)) + 3'd1,
                            sel_reg) == S_IDLE;
        case (pick(pos_of(st_reg) + 3'd1, sel_reg))
          S_C2: el_reg.data <= c2_reg;
          S_TS: el_reg.data <= lts_reg;
          default: el_reg.data <= {8'h00, status_reg};
        endcase
      end
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rd_ready = rd_ready_reg;
  assign el_valid = el_valid_reg;
  assign el = el_reg;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  a_default_sel: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> ctrl_reg[3:0] == 4'hF) else $error("default selection lost"); // R4
  a_nan_fill: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !rd.ch_one_avail && ctrl_reg[0] |=> el_reg.kind == K_CH1 && el_reg.data == NAN_VALUE)
    else $error("missing current not NaN"); // R5
  a_ts_restart: assert property (@(posedge pclk) disable iff (!presetn)
    ts_rst_reg |=> ts_reg == 32'h0000_0000 [*2]) else $error("timer not restarted"); // R6
  a_ts_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    tick && ts_reg == TS_LIMIT && !ts_rst_reg |=> ts_reg == 32'h0000_0000) else $error("timer not wrapped"); // R7
  a_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
    el_valid_reg && el_reg.kind == K_STAT |-> el_reg.data[31:15] == 17'h0_0000)
    else $error("status high bits set"); // R22
  a_elem_order: assert property (@(posedge pclk) disable iff (!presetn)
    advance && !el_reg.last |=> el_valid_reg && el_reg.kind > $past(el_reg.kind))
    else $error("element order broken"); // R23
  a_grade_high: assert property (@(posedge pclk) disable iff (!presetn)
    accept && !ctrl_reg[CTL_SORT] && rd.test_num == 3'd5 && rd.upper_fail
    |=> status_reg[12:8] == 5'b10101) else $error("grading high code wrong"); // R19
  a_sort_fail: assert property (@(posedge pclk) disable iff (!presetn)
    accept && ctrl_reg[CTL_SORT] && rd.all_fail |=> status_reg[12:8] == 5'b11111)
    else $error("sorting all-fail code wrong"); // R21
  a_pass_event: assert property (@(posedge pclk) disable iff (!presetn)
    accept && rd.limit_test_function && rd.test_num == 3'd0 && !rd.all_fail
    |=> evt_reg[EVT_ALL_PASS] [*2]) else $error("pass event not held"); // R20
  a_ovr_bits: assert property (@(posedge pclk) disable iff (!presetn)
    accept |=> status_reg[1:0] == {$past(rd.ch_two_overrange), $past(rd.ch_one_overrange)})
    else $error("overrange bits wrong"); // R10
endmodule : rse_encoder
`default_nettype wire

// *** hw/rse_encoder_unused_note.sv ***
// Intentionally empty: no further design content
`timescale 1ns/10ps
`default_nettype none
`default_nettype wire

// *** tb/rse_host_sink.sv ***
// Host side model: accepts string elements, prompt or stalling
`timescale 1ns/10ps
`default_nettype none
module rse_host_sink
  import rse_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic slow,
  input wire logic el_valid,
  input wire rse_elem_t el,
  output logic el_ready
);
  rse_elem_t got_q[$];
  ////////////////////////////////////////////////////////////////////////
  // Stall every other cycle when slow, so held elements get exercised
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      el_ready <= 1'b0;
    end else begin
      el_ready <= slow ? !el_ready : 1'b1;
    end
  end
  // Keep accepted elements in arrival order; selection goes as one bit per list entry
  always @(posedge pclk) begin
    if (presetn && el_valid && el_ready) begin
      got_q.push_back(el);
    end
  end
endmodule : rse_host_sink
`default_nettype wire

// *** tb/rse_encoder_test.sv ***
// Self-checking bench for the reading string encoder
`timescale 1ns/10ps
`default_nettype none
module rse_encoder_test;
  import rse_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rd_valid = 1'b0;
  rse_reading_t rd = '0;
  logic rd_ready;
  logic el_valid;
  rse_elem_t el;
  logic el_ready;
  logic slow = 1'b0;
  int err_count = 0;
  int n_compared = 0;
  logic [31:0] rdat;
  logic rerr;
  int base;
  ////////////////////////////////////////////////////////////////////////
  // 10 MHz clock
  always #50 pclk = ~pclk;
  rse_encoder dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rd_valid(rd_valid), .rd(rd), .rd_ready(rd_ready), .el_valid(el_valid), .el(el), .el_ready(el_ready));
  rse_host_sink host (.pclk(pclk), .presetn(presetn), .slow(slow), .el_valid(el_valid), .el(el),
    .el_ready(el_ready));
  ////////////////////////////////////////////////////////////////////////
  // Reporting
  task automatic give_verdict;
    $display("Counts: %0d compared, %0d mismatched", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : give_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic hang(input string nm);
    err_count++;
    $display("[ERR] %s expected handshake seen timeout", nm);
    give_verdict();
  endtask : hang
  ////////////////////////////////////////////////////////////////////////
  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) hang("pready");
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Offer one reading, then wait until n_el elements arrived and the block is idle
  task automatic send(input rse_reading_t r, input int n_el);
    int i;
    base = host.got_q.size();
    @(posedge pclk);
    rd <= r;
    rd_valid <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (rd_ready === 1'b1) break;
    end
    if (i == 20) hang("rd_ready");
    rd_valid <= 1'b0;
    for (i = 0; i < 60; i++) begin
      @(posedge pclk);
      if (host.got_q.size() == base + n_el && rd_ready === 1'b1) break;
    end
    if (i == 60) hang("string");
  endtask : send
  // Expected status word, worked out bit by bit
  function automatic logic [31:0] stat_of(input rse_reading_t r, input logic sort);
    logic [4:0] code;
    code = {r.upper_fail && r.test_num >= 3'd3, 1'b0, r.test_num};
    if (sort) code = r.all_fail ? 5'h1F : {2'b00, r.test_num};
    return {17'h0_0000, r.ch_two_output_on, r.ch_one_output_on, code, r.limit_test_function, r.ch_two_rel_on,
      r.ch_one_rel_on, r.ch_two_source_limited, r.ch_one_source_limited, r.filtered, r.ch_two_overrange,
      r.ch_one_overrange};
  endfunction : stat_of
  // Expected measurement event flag
  function automatic logic [31:0] evt_of(input logic [2:0] tn, input logic up, input logic sort);
    case (tn)
      3'd0: return 32'h0000_0020;
      3'd1: return 32'h0000_0001;
      3'd2: return 32'h0000_0002;
      3'd3: return sort ? 32'h0000_0008 : (up ? 32'h0000_0010 : 32'h0000_0004);
      3'd4: return sort ? 32'h0000_0010 : (up ? 32'h0000_0010 : 32'h0000_0008);
      3'd6: return (up && !sort) ? 32'h0000_0010 : 32'h0000_0000;
      default: return 32'h0000_0000;
    endcase
  endfunction : evt_of
  ////////////////////////////////////////////////////////////////////////
  // Reset values and an unmapped access
  task automatic t_reset;
    apb(1'b0, OFS_CTRL, 32'h0000_0000);
    chk("ctrl", 32'h0000_000F, rdat);
    chk("okay", 32'h0000_0000, {31'h0, rerr});
    apb(1'b0, 12'h020, 32'h0000_0000);
    chk("slverr", 32'h0000_0001, {31'h0, rerr});
    chk("unmapped", 32'h0000_0000, rdat);
    $display("reset test done");
  endtask : t_reset
  // All four elements with a stalling host and one current missing
  task automatic t_full;
    rse_reading_t r;
    for (int k = 0; k < 2; k++) begin
      r = '0;
      r.ch_one_current = 32'h1234_5678;
      r.ch_two_current = 32'h9ABC_DEF0;
      r.ch_one_avail = k[0];
      r.ch_two_avail = !k[0];
      {r.ch_one_overrange, r.ch_two_source_limited, r.ch_one_rel_on, r.ch_two_output_on} = {4{!k[0]}};
      {r.ch_two_overrange, r.filtered, r.ch_one_source_limited, r.ch_two_rel_on, r.ch_one_output_on} = {5{k[0]}};
      r.limit_test_function = 1'b1;
      r.test_num = 3'd6;
      r.upper_fail = 1'b1;
      slow <= 1'b1;
      send(r, 4);
      slow <= 1'b0;
      for (int j = 0; j < 4; j++) begin
        chk("kind", j, host.got_q[base + j].kind);
        chk("last", j == 3, host.got_q[base + j].last);
      end
      chk("ch1", k ? r.ch_one_current : NAN_VALUE, host.got_q[base].data);
      chk("ch2", k ? NAN_VALUE : r.ch_two_current, host.got_q[base + 1].data);
      chk("status", stat_of(r, 1'b0), host.got_q[base + 3].data);
      apb(1'b0, OFS_STAT, 32'h0000_0000);
      chk("stat_reg", stat_of(r, 1'b0), rdat);
    end
    $display("full string test done");
  endtask : t_full
  // Every element subset, in fixed order
  task automatic t_sel;
    int n;
    for (int s = 0; s < 16; s++) begin
      apb(1'b1, OFS_CTRL, s);
      n = s[0] + s[1] + s[2] + s[3];
      send('0, n);
      for (int b = 0; b < 4; b++) begin
        if (s[b]) begin
          chk("sel_kind", b, host.got_q[base].kind);
          base++;
        end
      end
    end
    $display("selection test done");
  endtask : t_sel
  // Limit codes and events in grading, then sorting mode
  task automatic t_code(input logic sort);
    rse_reading_t r;
    apb(1'b1, OFS_CTRL, sort ? 32'h0000_0028 : 32'h0000_0008);
    for (int t = 0; t < 14; t++) begin
      apb(1'b1, OFS_EVT, 32'h0000_003F);
      r = '0;
      r.limit_test_function = 1'b1;
      r.test_num = t[3:1];
      r.upper_fail = !sort && t[0];
      r.all_fail = sort && t[0];
      send(r, 1);
      chk("code", stat_of(r, sort), host.got_q[base].data);
      apb(1'b0, OFS_EVT, 32'h0000_0000);
      chk("event", r.all_fail ? 32'h0000_0000 : evt_of(r.test_num, t[0], sort), rdat);
    end
    $display("limit code test done");
  endtask : t_code
  // Timer restart, then buffered stamps in absolute and delta format
  task automatic t_time;
    rse_reading_t r;
    apb(1'b1, OFS_CTRL, 32'h0000_010F);
    apb(1'b0, OFS_TIME, 32'h0000_0000);
    chk("ts_zero", 1, rdat <= 32'd1);
    repeat (200) @(posedge pclk);
    apb(1'b0, OFS_TIME, 32'h0000_0000);
    chk("ts_run", 1, rdat >= 32'd19 && rdat <= 32'd22);
    apb(1'b1, OFS_CTRL, 32'h0000_0204);
    r = '0;
    r.buffered = 1'b1;
    send(r, 1);
    chk("buf_first", 32'h0000_0000, host.got_q[base].data);
    repeat (300) @(posedge pclk);
    send(r, 1);
    chk("buf_abs", 1, host.got_q[base].data >= 32'd29 && host.got_q[base].data <= 32'd33);
    apb(1'b1, OFS_CTRL, 32'h0000_0014);
    repeat (100) @(posedge pclk);
    send(r, 1);
    chk("buf_delta", 1, host.got_q[base].data >= 32'd9 && host.got_q[base].data <= 32'd13);
    apb(1'b0, OFS_LTS, 32'h0000_0000);
    chk("lts", 1, rdat >= 32'd9 && rdat <= 32'd13);
    $display("timestamp test done");
  endtask : t_time
  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_full();
    t_sel();
    t_code(1'b0);
    t_code(1'b1);
    t_time();
    give_verdict();
  end
endmodule : rse_encoder_test
`default_nettype wire
